// ==== hw/ufm_rx_map.vh ====
// constants for the write-only two-wire serial receiver
`ifndef UFM_RX_MAP_VH
`define UFM_RX_MAP_VH
`define UFM_ADDR_W        7
`define UFM_BYTE_W        8
`define UFM_BIT_CNT_W     4
`define UFM_LAST_DATA_BIT 4'h7
`define UFM_ACK_SLOT_BIT  4'h8
`define UFM_DIR_WRITE     1'b0
`define UFM_GCALL_ADDR    7'h00
`define UFM_OWN_ADDR_RST  7'h20
`endif

// ==== hw/sync_2ff.v ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module sync_2ff #(
  parameter [0:0] RST_VAL = 1'h1
) (
  input  wire clock_in,
  input  wire reset_n_in,
  input  wire async_in,
  output wire sync_out
);
  reg meta_r;
  reg sync_r;
  // preset to the idle level of the line so reset release shows no false edge
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// ==== hw/ufm_slave_rx.v ====
// receive-only slave for the push-pull write-only two-wire link
`timescale 1ns/1ns
`include "ufm_rx_map.vh"
// How it works
// - data flows master to slave only
// - slave only receives, never transmits
// - slave never stretches; no arbitration
// - start, stop, 7-bit address mandatory
// - both lines are inputs here
// - data falling, clock high: start
// - data rising, clock high: stop
// - bytes eight bits, msb first
// - seven-bit address plus write bit
// - any start resets to address phase
module ufm_slave_rx (
  input  wire       clock_in,
  input  wire       reset_n_in,
  input  wire [6:0] own_addr_in,
  input  wire       gcall_en_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg  [7:0] rx_data_out,
  output reg        rx_valid_out,
  output reg        rx_first_out,
  output reg        start_seen_out,
  output reg        stop_seen_out,
  output wire       busy_out,
  output wire       selected_out,
  output reg        frame_err_out
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_SKIP = 4'b1000;

  reg        rst_m_r;
  reg        rst_s_r;
  wire       rst_n;
  wire       scl_s;
  wire       sda_s;
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [3:0] state_r;
  reg  [3:0] state_nxt;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg        first_pend_r;
  wire [6:0] own_addr_s;
  wire       gcall_en_s;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;

  // 5 MHz halves still span several clocks
  sync_2ff #(.RST_VAL (1'h1)) u_sync_scl (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (scl_in),
    .sync_out   (scl_s)
  );
  sync_2ff #(.RST_VAL (1'h1)) u_sync_sda (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (sda_in),
    .sync_out   (sda_s)
  );

  // address straps: per-bit sync, so change them only while the bus is idle
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr0 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[0]),
    .sync_out   (own_addr_s[0])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr1 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[1]),
    .sync_out   (own_addr_s[1])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr2 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[2]),
    .sync_out   (own_addr_s[2])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr3 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[3]),
    .sync_out   (own_addr_s[3])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr4 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[4]),
    .sync_out   (own_addr_s[4])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr5 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[5]),
    .sync_out   (own_addr_s[5])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_addr6 (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (own_addr_in[6]),
    .sync_out   (own_addr_s[6])
  );
  sync_2ff #(.RST_VAL (1'h0)) u_sync_gcall (
    .clock_in   (clock_in),
    .reset_n_in (rst_n),
    .async_in   (gcall_en_in),
    .sync_out   (gcall_en_s)
  );

  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire byte_done = scl_rise && (bit_cnt_r == `UFM_LAST_DATA_BIT);
  wire slot_done = scl_rise && (bit_cnt_r == `UFM_ACK_SLOT_BIT);
  wire [7:0] byte_val = {shift_r[6:0], sda_s};
  wire addr_hit = (byte_val[7:1] == own_addr_s) ||
                  (gcall_en_s && (byte_val[7:1] == `UFM_GCALL_ADDR));
  wire addr_ok = addr_hit && (byte_val[0] == `UFM_DIR_WRITE);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_ADDR: begin
        if (byte_done)
          state_nxt = addr_ok ? ST_DATA : ST_SKIP;
      end
      ST_DATA: state_nxt = ST_DATA;
      ST_SKIP: state_nxt = ST_SKIP;
      default: state_nxt = ST_IDLE;
    endcase
    if (start_det)
      state_nxt = ST_ADDR;
    else if (stop_det)
      state_nxt = ST_IDLE;
  end

  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= ST_IDLE;
      bit_cnt_r      <= 4'h0;
      shift_r        <= 8'h00;
      rx_data_out    <= 8'h00;
      rx_valid_out   <= 1'b0;
      rx_first_out   <= 1'b0;
      first_pend_r   <= 1'b0;
      start_seen_out <= 1'b0;
      stop_seen_out  <= 1'b0;
      frame_err_out  <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      rx_valid_out   <= 1'b0;
      start_seen_out <= start_det;
      stop_seen_out  <= stop_det;
      frame_err_out  <= 1'b0;
      if (start_det || stop_det) begin
        bit_cnt_r    <= 4'h0;
        first_pend_r <= 1'b1;
        // void message; the stop's own clock rise counts one bit
        if (stop_det && state_r == ST_ADDR && bit_cnt_r <= 4'h1)
          frame_err_out <= 1'b1;
      end else if (scl_rise && state_r != ST_IDLE) begin
        // msb first, eight bits plus slot
        if (slot_done) begin
          bit_cnt_r <= 4'h0;
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          shift_r   <= byte_val;
        end
        // data bytes only after matched address
        if (byte_done && state_r == ST_DATA) begin
          rx_data_out  <= byte_val;
          rx_valid_out <= 1'b1;
          rx_first_out <= first_pend_r;
          first_pend_r <= 1'b0;
        end
        if (slot_done && !sda_s)
          frame_err_out <= 1'b1;
      end
    end
  end

  // no driver exists: outputs only to user side
  // clock never held, stretched or driven
  assign busy_out     = (state_r != ST_IDLE);
  assign selected_out = (state_r == ST_DATA);
endmodule

// ==== sim/ufm_mst.sv ====
// master model driving the link
`timescale 1ns/1ns
module ufm_mst #(parameter int QUARTER = 4) (
  input  wire clk,
  output reg  scl = 1'h1,
  output reg  sda = 1'h1
);
  // only this model drives scl and sda
  // divider count sets the bus clock
  task q; repeat (QUARTER) @(posedge clk); endtask
  task start; begin q; sda <= 1; q; scl <= 1; q; sda <= 0; q; scl <= 0; q; end endtask
  task xfer(input [8:0] b); for (int k = 8; k >= 0; k--) begin sda <= b[k]; q; scl <= 1; q; q; scl <= 0; q; end endtask
  task stop; begin sda <= 0; q; scl <= 1; q; sda <= 1; q; end endtask
endmodule

// ==== sim/ufm_rx_chk_sva.sv ====
// port checks for the receive slave
`timescale 1ns/1ns
module ufm_rx_chk (
  input wire       clock_in,
  input wire       reset_n_in,
  input wire       scl_in,
  input wire       sda_in,
  input wire       rx_valid_out,
  input wire       start_seen_out,
  input wire       stop_seen_out,
  input wire       busy_out,
  input wire       selected_out,
  input wire [7:0] rx_data_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_go; scl_in && $fell(sda_in); endsequence
  sequence s_end; scl_in && $rose(sda_in); endsequence
  a_start_seen: assert property (s_go |-> ##[1:8] start_seen_out) else $error("start");
  a_stop_seen: assert property (s_end |-> ##[1:8] stop_seen_out) else $error("stop");
  a_start_pulse: assert property (start_seen_out |=> !start_seen_out) else $error("pulse");
  a_start_rearm: assert property (start_seen_out |-> ##[0:2] busy_out && !selected_out) else $error("rearm");
  a_stop_idle: assert property (stop_seen_out |-> ##[0:2] !busy_out && !selected_out) else $error("idle");
  a_valid_sel: assert property (rx_valid_out |-> selected_out) else $error("unselected");
  a_byte_hold: assert property (rx_valid_out |=> (!rx_valid_out && $stable(rx_data_out)) [*8]) else $error("hold");
  a_addr_first: assert property (start_seen_out |-> (!selected_out) [*8]) else $error("early select");
endmodule
bind ufm_slave_rx ufm_rx_chk ufm_rx_chk_inst (
  .clock_in       (clock_in),
  .reset_n_in     (reset_n_in),
  .scl_in         (scl_in),
  .sda_in         (sda_in),
  .rx_valid_out   (rx_valid_out),
  .start_seen_out (start_seen_out),
  .stop_seen_out  (stop_seen_out),
  .busy_out       (busy_out),
  .selected_out   (selected_out),
  .rx_data_out    (rx_data_out)
);

// ==== sim/tb_ufm_slave_rx.sv ====
// self-checking bench for the receive slave
`timescale 1ns/1ns
module tb_ufm_slave_rx;
  reg        clock_in = 0, reset_n_in = 0, gcall_en_in = 0, ok;
  reg  [6:0] own_addr_in = 7'h20, a;
  reg [31:0] lf = 32'h1C49;
  reg  [8:0] q[$];
  wire       scl_in, sda_in, rx_valid_out, rx_first_out, frame_err_out;
  wire [7:0] rx_data_out;
  integer    num_errors = 0, cmp_count = 0, cyc = 0, t, i, n, fe_exp = 0, fe_got = 0;
  always #5 clock_in = ~clock_in;
  ufm_mst ufm_mst_inst (.clk(clock_in), .scl(scl_in), .sda(sda_in));
  ufm_slave_rx ufm_slave_rx_inst (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .own_addr_in    (own_addr_in),
    .gcall_en_in    (gcall_en_in),
    .scl_in         (scl_in),
    .sda_in         (sda_in),
    .rx_data_out    (rx_data_out),
    .rx_valid_out   (rx_valid_out),
    .rx_first_out   (rx_first_out),
    .start_seen_out (),
    .stop_seen_out  (),
    .busy_out       (),
    .selected_out   (),
    .frame_err_out  (frame_err_out)
  );
  function [31:0] nx(input [31:0] x); nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]}; endfunction
  task chk(input string s, input [8:0] x, y);
    begin cmp_count++; if (x !== y) begin num_errors++; $display("unexpected %s exp %h got %h", s, x, y); end end
  endtask
  task tally_and_finish;
    begin $display("errors %0d of %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish; end
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (rx_valid_out === 1) chk("byte", q.size() ? q.pop_front() : 9'h1FF, {rx_first_out, rx_data_out});
    if (frame_err_out === 1) fe_got++;
    if (cyc == 30000) begin num_errors++; tally_and_finish; end
  end
  initial begin
    @(posedge clock_in);
    own_addr_in <= {1'h1, lf[5:0]};
    repeat (19) @(posedge clock_in);
    reset_n_in <= 1;
    for (t = 0; t < 12; t++) begin
      lf = nx(lf); gcall_en_in <= lf[5]; n = lf[4:3];
      a = lf[0] ? own_addr_in : lf[1] ? 7'h00 : lf[14:8];
      // write to own or general call
      ok = !lf[2] && (a == own_addr_in || a == 0 && lf[5]);
      // ninth slot of the address driven low once, to trip the slot check
      ufm_mst_inst.start; ufm_mst_inst.xfer({a, lf[2], t != 4});
      if (t == 4) fe_exp++;
      for (i = 0; i <= n; i++) begin
        lf = nx(lf); if (ok) q.push_back({i == 0, lf[7:0]});
        ufm_mst_inst.xfer({lf[7:0], 1'h1});
      end
      if (lf[9] || t == 11) ufm_mst_inst.stop;
      if (t == 7) begin ufm_mst_inst.start; ufm_mst_inst.stop; fe_exp++; end
    end
    repeat (20) @(posedge clock_in);
    chk("left", 0, q.size());
    chk("frame_err", fe_exp, fe_got);
    tally_and_finish;
  end
endmodule
